// [core/gocr_pkg.sv]
/*
  package of the global option configuration registers: offsets, field
  positions, reset values, decode constants and the carrier structs.
  assumes nothing of its surroundings.
*/
package gocr_pkg;

  // ----------------------------------------------------------------------
  // register offsets and entry key
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_PORT = 8'h26;
  localparam logic [7:0] OFS_RSVD = 8'h27;
  localparam logic [7:0] OFS_ROM_DEC = 8'h28;
  localparam logic [7:0] OFS_PIN_FUNC = 8'h29;
  localparam logic [7:0] OFS_UNIT_SEL = 8'h07;
  localparam logic [7:0] ENTRY_KEY = 8'h87;
  localparam logic [7:0] EXIT_KEY = 8'haa;
  localparam logic [7:0] PORT_LO_INDEX = 8'h2e;
  localparam logic [7:0] PORT_HI_INDEX = 8'h4e;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_PORT_SEL = 6;
  localparam int BIT_LOCK = 5;
  localparam int BIT_FLOPPY_DIS = 3;
  localparam int BIT_PARPORT_DIS = 2;
  localparam int BIT_UART1_DIS = 1;
  localparam int BIT_UART2_DIS = 0;
  localparam int BIT_LOW_DEC_DIS = 4;
  localparam int BIT_HIGH_DEC_DIS = 3;
  localparam int BIT_ALERT_SEL = 6;
  localparam int BIT_UART1_GPIO = 3;
  localparam int FLD_FLASH_LSB = 5;
  localparam int FLD_FAN_LSB = 1;
  localparam int BIT_MODE_RSVD = 2;
  localparam int BIT_FLOPPY_IRQ = 3;
  localparam int BIT_PARPORT_IRQ = 4;
  localparam int BIT_UART_IRQ = 3;

  // ----------------------------------------------------------------------
  // writable masks and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MASK_IRQ_PORT = 8'h6f;
  localparam logic [7:0] MASK_ROM_DEC = 8'h7f;
  localparam logic [7:0] MASK_PIN_FUNC = 8'h4e;
  localparam logic [7:0] RST_IRQ_PORT = 8'h00;
  localparam logic [7:0] RST_ROM_DEC = 8'h50;
  localparam logic [7:0] RST_PIN_FUNC = 8'h00;
  localparam logic [7:0] RST_UNIT_SEL = 8'h00;

  // ----------------------------------------------------------------------
  // decode constants
  // ----------------------------------------------------------------------
  localparam logic [1:0] FAN_FUNC = 2'h0;
  localparam logic [1:0] FAN_GPIO = 2'h1;
  localparam logic [15:0] LOW_RANGE_TAG = 16'h000e;
  localparam logic [11:0] HIGH_RANGE_TAG = 12'hffe;

  // carrier of the per-unit legacy irq bits seen from the function units
  typedef struct packed {
    logic floppyDo;
    logic parportDc;
    logic uart1Hs;
    logic uart2Hs;
  } gocr_legacy_s;

  // carrier of the pin routing outputs
  typedef struct packed {
    logic alertIsSmi;
    logic uart1AsGpio;
    logic fanAsGpio;
  } gocr_route_s;

endpackage : gocr_pkg

// [core/gocr_irq_gate.sv]
/*
  one legacy irq gate: the unit's own register bit takes part in irq
  selection only while its legacy disable bit is clear.
  assumes a registered disable bit and a same-clock unit bit.
*/
`timescale 1ns/1ps
module gocr_irq_gate
  import gocr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic legacyDisable,
  input wire logic unitBit,
  output logic gateOut
);

  // register the gated bit so the top output comes from a flip-flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gateOut <= 1'b1;
    end else begin
      gateOut <= legacyDisable ? 1'b1 : unitBit;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_gate_follow;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> gateOut == ($past(legacyDisable) | $past(unitBit));
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("legacy gate wrong");

endmodule : gocr_irq_gate

// [core/gocr_regs.sv]
/*
  global option configuration register bank: entry key on the index port,
  index/data access to the unit select, irq/port option, rom decode option
  and pin function select registers, with the decoded controls driven out.
  assumes a host interface that presents one byte write or read strobe per
  cycle, already on this clock; the port select strap is a raw pin.
*/
`timescale 1ns/1ps
module gocr_regs
  import gocr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfgPortSelStrap,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioAddr,
  input wire logic [7:0] ioWdata,
  input wire gocr_legacy_s unitBits,
  input wire logic [19:0] memAddrHigh,
  input wire logic overtempAlertIn,
  input wire logic sysMgmtIrqIn,
  output logic [7:0] ioRdata,
  output logic ioRvalid,
  output logic cfgMode,
  output logic [7:0] unitSelect,
  output gocr_legacy_s irqGateOut,
  output logic [1:0] flashSize,
  output logic parportModeOk,
  output logic biosLowHit,
  output logic biosHighHit,
  output gocr_route_s routeOut,
  output logic sharedPinOut,
  output logic gpioGroupSixEn,
  output logic fanAsGpio
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_KEY1 = 2'b01,
    ST_CFG = 2'b10
  } gocr_key_e;

  gocr_key_e key_ff;
  gocr_key_e nxt_key;
  logic strapMeta_ff;
  logic strapSync_ff;
  logic [2:0] strapStage_ff;
  logic [7:0] index_ff;
  logic [7:0] irqPort_ff;
  logic [7:0] romDec_ff;
  logic [7:0] pinFunc_ff;
  logic [7:0] unitSel_ff;
  logic [7:0] portBase;
  logic idxHit;
  logic dataHit;
  logic cfgActive;
  logic regWrite;
  logic regRead;
  logic [7:0] rdMux;

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  // two-flop synchroniser for the strap pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strapMeta_ff <= 1'b0;
      strapSync_ff <= 1'b0;
      strapStage_ff <= 3'h0;
    end else begin
      strapMeta_ff <= cfgPortSelStrap;
      strapSync_ff <= strapMeta_ff;
      strapStage_ff <= {strapStage_ff[1:0], 1'b1}; // marks when the synchronised strap is valid
    end
  end

  // ----------------------------------------------------------------------
  // port decode and key sequence
  // ----------------------------------------------------------------------
  // the index port follows the port select bit; data port is index plus one
  always_comb begin
    portBase = irqPort_ff[BIT_PORT_SEL] ? PORT_HI_INDEX : PORT_LO_INDEX;
    idxHit = ioAddr == portBase;
    dataHit = ioAddr == (portBase + 8'h01);
    cfgActive = key_ff == ST_CFG;
    regWrite = cfgActive && ioWrite && dataHit;
    regRead = cfgActive && ioRead && dataHit;
  end

  // two consecutive key writes to the index port enter configuration
  always_comb begin
    nxt_key = key_ff;
    unique case (key_ff)
      ST_IDLE: begin
        if (ioWrite && idxHit && ioWdata == ENTRY_KEY) begin
          nxt_key = ST_KEY1;
        end
      end
      ST_KEY1: begin
        if (ioWrite && idxHit) begin
          nxt_key = (ioWdata == ENTRY_KEY) ? ST_CFG : ST_IDLE;
        end else if (ioWrite) begin
          nxt_key = ST_IDLE;
        end
      end
      ST_CFG: begin
        if (ioWrite && idxHit && ioWdata == EXIT_KEY) begin
          nxt_key = ST_IDLE;
        end
      end
      default: begin
        nxt_key = ST_IDLE;
      end
    endcase
  end

  // key state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_ff <= ST_IDLE;
    end else begin
      key_ff <= nxt_key;
    end
  end

  // index register, written through the index port while configuring
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      index_ff <= 8'h00;
    end else if (cfgActive && ioWrite && idxHit) begin
      index_ff <= ioWdata;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // irq/port option: strap loads the port select once, at the third edge after release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqPort_ff <= RST_IRQ_PORT;
    end else if (strapStage_ff[2:1] == 2'b01) begin
      irqPort_ff[BIT_PORT_SEL] <= strapSync_ff;
    end else if (regWrite && index_ff == OFS_IRQ_PORT) begin
      if (!irqPort_ff[BIT_LOCK]) begin
        irqPort_ff <= ioWdata & MASK_IRQ_PORT;
      end else begin
        irqPort_ff[BIT_LOCK] <= ioWdata[BIT_LOCK]; // lock stays clearable
      end
    end
  end

  // rom decode option
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      romDec_ff <= RST_ROM_DEC;
    end else if (regWrite && index_ff == OFS_ROM_DEC && !irqPort_ff[BIT_LOCK]) begin
      romDec_ff <= ioWdata & MASK_ROM_DEC;
    end
  end

  // pin function select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinFunc_ff <= RST_PIN_FUNC;
    end else if (regWrite && index_ff == OFS_PIN_FUNC && !irqPort_ff[BIT_LOCK]) begin
      pinFunc_ff <= ioWdata & MASK_PIN_FUNC;
    end
  end

  // logical unit select
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unitSel_ff <= RST_UNIT_SEL;
    end else if (regWrite && index_ff == OFS_UNIT_SEL && !irqPort_ff[BIT_LOCK]) begin
      unitSel_ff <= ioWdata;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // read mux; locked or unmapped reads return zero
  always_comb begin
    rdMux = 8'h00;
    if (!irqPort_ff[BIT_LOCK]) begin
      unique case (index_ff)
        OFS_IRQ_PORT: rdMux = irqPort_ff;
        OFS_ROM_DEC: rdMux = romDec_ff;
        OFS_PIN_FUNC: rdMux = pinFunc_ff;
        OFS_UNIT_SEL: rdMux = unitSel_ff;
        default: rdMux = 8'h00;
      endcase
    end
  end

  // read data is answered one cycle after the read strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ioRdata <= 8'h00;
      ioRvalid <= 1'b0;
    end else begin
      ioRvalid <= regRead;
      ioRdata <= regRead ? rdMux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------------
  gocr_irq_gate u_gate_floppy (
    .clock(clock),
    .rst_n(rst_n),
    .legacyDisable(irqPort_ff[BIT_FLOPPY_DIS]),
    .unitBit(unitBits.floppyDo),
    .gateOut(irqGateOut.floppyDo)
  );

  gocr_irq_gate u_gate_parport (
    .clock(clock),
    .rst_n(rst_n),
    .legacyDisable(irqPort_ff[BIT_PARPORT_DIS]),
    .unitBit(unitBits.parportDc),
    .gateOut(irqGateOut.parportDc)
  );

  gocr_irq_gate u_gate_uart1 (
    .clock(clock),
    .rst_n(rst_n),
    .legacyDisable(irqPort_ff[BIT_UART1_DIS]),
    .unitBit(unitBits.uart1Hs),
    .gateOut(irqGateOut.uart1Hs)
  );

  gocr_irq_gate u_gate_uart2 (
    .clock(clock),
    .rst_n(rst_n),
    .legacyDisable(irqPort_ff[BIT_UART2_DIS]),
    .unitBit(unitBits.uart2Hs),
    .gateOut(irqGateOut.uart2Hs)
  );

  // registered pin routing and rom decode outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgMode <= 1'b0;
      unitSelect <= RST_UNIT_SEL;
      flashSize <= RST_ROM_DEC[FLD_FLASH_LSB +: 2];
      parportModeOk <= 1'b1;
      biosLowHit <= 1'b0;
      biosHighHit <= 1'b0;
      routeOut <= '0;
      sharedPinOut <= 1'b1;
      gpioGroupSixEn <= 1'b0;
      fanAsGpio <= 1'b0;
    end else begin
      cfgMode <= cfgActive;
      unitSelect <= unitSel_ff;
      flashSize <= romDec_ff[FLD_FLASH_LSB +: 2];
      parportModeOk <= !romDec_ff[BIT_MODE_RSVD];
      biosLowHit <= !romDec_ff[BIT_LOW_DEC_DIS] && memAddrHigh[19:4] == LOW_RANGE_TAG;
      biosHighHit <= !romDec_ff[BIT_HIGH_DEC_DIS] && memAddrHigh[19:8] == HIGH_RANGE_TAG;
      routeOut.alertIsSmi <= pinFunc_ff[BIT_ALERT_SEL];
      routeOut.uart1AsGpio <= pinFunc_ff[BIT_UART1_GPIO];
      routeOut.fanAsGpio <= pinFunc_ff[FLD_FAN_LSB +: 2] == FAN_GPIO;
      sharedPinOut <= pinFunc_ff[BIT_ALERT_SEL] ? sysMgmtIrqIn : overtempAlertIn;
      gpioGroupSixEn <= pinFunc_ff[BIT_UART1_GPIO];
      fanAsGpio <= pinFunc_ff[FLD_FAN_LSB +: 2] == FAN_GPIO;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_key_twice;
    @(posedge clock) disable iff (!rst_n)
      (key_ff == ST_KEY1 && ioWrite && idxHit && ioWdata == ENTRY_KEY) |=> cfgActive;
  endproperty
  a_key_twice: assert property (p_key_twice) else $error("second key did not enter");

  property p_lock_blocks;
    @(posedge clock) disable iff (!rst_n)
      (regWrite && index_ff == OFS_ROM_DEC && irqPort_ff[BIT_LOCK]) |=> $stable(romDec_ff);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked write took effect");

  property p_locked_read;
    @(posedge clock) disable iff (!rst_n)
      (regRead && irqPort_ff[BIT_LOCK]) |=> ioRvalid && ioRdata == 8'h00;
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read returned data");

  property p_flash;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> flashSize == $past(romDec_ff[6:5]);
  endproperty
  a_flash: assert property (p_flash) else $error("flash size mismatch");

  property p_low_off;
    @(posedge clock) disable iff (!rst_n)
      romDec_ff[BIT_LOW_DEC_DIS] |=> !biosLowHit;
  endproperty
  a_low_off: assert property (p_low_off) else $error("low range decoded while off");

  property p_high_off;
    @(posedge clock) disable iff (!rst_n)
      romDec_ff[BIT_HIGH_DEC_DIS] |=> !biosHighHit;
  endproperty
  a_high_off: assert property (p_high_off) else $error("high range decoded while off");

  property p_pin;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> sharedPinOut == ($past(pinFunc_ff[6]) ? $past(sysMgmtIrqIn) : $past(overtempAlertIn));
  endproperty
  a_pin: assert property (p_pin) else $error("shared pin wrong source");

  property p_rsvd;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |-> (pinFunc_ff & ~MASK_PIN_FUNC) == 8'h00 && romDec_ff[7] == 1'b0 && (irqPort_ff & ~MASK_IRQ_PORT) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

endmodule : gocr_regs

// [sim/gocr_host_model.sv]
/*
  host side model: drives byte strokes onto the configuration index and
  data ports of the option register bank.
  assumes the bank takes a stroke on the rising edge and answers a read
  with a registered one-cycle pulse.
*/
`timescale 1ns/1ps
module gocr_host_model
  import gocr_pkg::*;
(
  input wire logic clock,
  output logic ioWrite,
  output logic ioRead,
  output logic [7:0] ioAddr,
  output logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata,
  input wire logic ioRvalid
);
  // ----------------------------------------------------------------------
  // bus strokes
  // ----------------------------------------------------------------------
  // idle bus at time zero
  initial begin
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = 8'h00;
    ioWdata = 8'h00;
  end

  // a released bus shows the inverse of the last byte, never a stale copy
  task automatic release_bus();
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = ~ioAddr;
    ioWdata = ~ioWdata;
  endtask : release_bus

  // one write stroke, entered just after a rising edge; one idle cycle follows
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    ioAddr = addr;
    ioWdata = data;
    ioWrite = 1'b1;
    @(posedge clock);
    #1;
    release_bus();
    @(posedge clock);
    #1;
  endtask : wr

  // one read stroke; the answer stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    ioAddr = addr;
    ioRead = 1'b1;
    @(posedge clock);
    #1;
    data = ioRdata;
    valid = ioRvalid;
    release_bus();
    @(posedge clock);
    #1;
  endtask : rd

  // ----------------------------------------------------------------------
  // configuration sequences
  // ----------------------------------------------------------------------
  // entry key written twice in a row to the index port
  task automatic enter(input logic [7:0] port);
    wr(port, ENTRY_KEY);
    wr(port, ENTRY_KEY);
  endtask : enter

  // exit key to the index port
  task automatic leave(input logic [7:0] port);
    wr(port, EXIT_KEY);
  endtask : leave

  // index stroke then data stroke
  task automatic reg_wr(input logic [7:0] port, input logic [7:0] idx, input logic [7:0] data);
    wr(port, idx);
    wr(port + 8'h01, data);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] port, input logic [7:0] idx, output logic [7:0] data,
                        output logic valid);
    wr(port, idx);
    rd(port + 8'h01, data, valid);
  endtask : reg_rd

endmodule : gocr_host_model

// [sim/gocr_regs_tb_top.sv]
/*
  self-checking bench of the option register bank: a behavioural register
  model is compared with every register read and every decoded output but cfgMode.
  assumes the host model drives the io strokes and this module the unit
  bits, memory address and pin sources.
*/
`timescale 1ns/1ps
module gocr_regs_tb_top;
  import gocr_pkg::*;

  logic clock, rst_n, cfgPortSelStrap, ioWrite, ioRead, ioRvalid, cfgMode;
  logic [7:0] ioAddr, ioWdata, ioRdata, unitSelect;
  gocr_legacy_s unitBits, irqGateOut;
  gocr_route_s routeOut;
  logic [19:0] memAddrHigh;
  logic overtempAlertIn, sysMgmtIrqIn, parportModeOk, biosLowHit, biosHighHit;
  logic sharedPinOut, gpioGroupSixEn, fanAsGpio, v;
  logic [1:0] flashSize;
  logic [7:0] m26, m28, m29, m07, port, old, d, q;
  logic [7:0] tbl [5] = '{OFS_UNIT_SEL, OFS_IRQ_PORT, OFS_RSVD, OFS_ROM_DEC, OFS_PIN_FUNC};
  int errors = 0;
  int checksDone = 0;

  gocr_regs i_dut (.clock(clock), .rst_n(rst_n), .cfgPortSelStrap(cfgPortSelStrap), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata), .unitBits(unitBits), .memAddrHigh(memAddrHigh),
    .overtempAlertIn(overtempAlertIn), .sysMgmtIrqIn(sysMgmtIrqIn), .ioRdata(ioRdata), .ioRvalid(ioRvalid),
    .cfgMode(cfgMode), .unitSelect(unitSelect), .irqGateOut(irqGateOut), .flashSize(flashSize),
    .parportModeOk(parportModeOk), .biosLowHit(biosLowHit), .biosHighHit(biosHighHit), .routeOut(routeOut),
    .sharedPinOut(sharedPinOut), .gpioGroupSixEn(gpioGroupSixEn), .fanAsGpio(fanAsGpio));

  gocr_host_model i_host (.clock(clock), .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .ioRvalid(ioRvalid));

  // ----------------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------------
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // cuts a hang short
  initial begin
    #200us;
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // model and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // register model write; lock leaves only the lock bit writable
  task automatic mdl_wr(input logic [7:0] idx, input logic [7:0] dat);
    if (m26[5]) begin
      if (idx == OFS_IRQ_PORT) m26[5] = dat[5];
    end else begin
      case (idx)
        OFS_IRQ_PORT: m26 = dat & 8'h6f;
        OFS_ROM_DEC: m28 = dat & 8'h7f;
        OFS_PIN_FUNC: m29 = dat & 8'h4e;
        OFS_UNIT_SEL: m07 = dat;
        default: ;
      endcase
    end
  endtask : mdl_wr

  function automatic logic [7:0] exp_rd(input logic [7:0] idx);
    if (m26[5]) return 8'h00;
    case (idx)
      OFS_IRQ_PORT: return m26;
      OFS_ROM_DEC: return m28;
      OFS_PIN_FUNC: return m29;
      OFS_UNIT_SEL: return m07;
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  // decoded outputs against the model
  task automatic chk_out();
    chk(irqGateOut, unitBits | m26[3:0], "irq gates");
    chk(flashSize, m28[6:5], "flash size");
    chk(parportModeOk, !m28[2], "parallel mode");
    chk(biosLowHit, memAddrHigh[19:4] == 16'h000e && !m28[4], "low bios hit");
    chk(biosHighHit, memAddrHigh[19:8] == 12'hffe && !m28[3], "high bios hit");
    chk(routeOut, {m29[6], m29[3], m29[2:1] == 2'b01}, "route");
    chk(sharedPinOut, m29[6] ? sysMgmtIrqIn : overtempAlertIn, "shared pin");
    chk(gpioGroupSixEn, m29[3], "gpio group");
    chk(fanAsGpio, m29[2:1] == 2'b01, "fan pins");
    chk(unitSelect, m07, "unit select");
  endtask : chk_out

  // ----------------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------------
  task automatic do_reset(input logic strap);
    cfgPortSelStrap = strap;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    m26 = {1'b0, strap, 6'h00};
    m28 = 8'h50;
    m29 = 8'h00;
    m07 = 8'h00;
    port = strap ? 8'h4e : 8'h2e;
  endtask : do_reset

  // random unit bits, pin sources and memory address, mostly in the bios ranges
  task automatic drive_side();
    unitBits = 4'($urandom);
    overtempAlertIn = 1'($urandom);
    sysMgmtIrqIn = 1'($urandom);
    case ($urandom % 3)
      0: memAddrHigh = {16'h000e, 4'($urandom)};
      1: memAddrHigh = {12'hffe, 8'($urandom)};
      default: memAddrHigh = 20'($urandom) & 20'h7ffff;
    endcase
  endtask : drive_side

  // write, read back and compare everything
  task automatic acc(input logic [7:0] idx, input logic [7:0] dat);
    drive_side();
    i_host.reg_wr(port, idx, dat);
    mdl_wr(idx, dat);
    port = m26[6] ? PORT_HI_INDEX : PORT_LO_INDEX;
    i_host.reg_rd(port, idx, q, v);
    chk(v, 1'b1, "read answer");
    chk(q, exp_rd(idx), "read data");
    chk_out();
  endtask : acc

  // read every register after reset
  task automatic chk_reset_vals();
    for (int i = 0; i < 5; i++) begin
      i_host.reg_rd(port, tbl[i], q, v);
      chk(q, exp_rd(tbl[i]), "reset value");
    end
    chk_out();
  endtask : chk_reset_vals

  task automatic give_verdict();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    cfgPortSelStrap = 1'b1;
    unitBits = '0;
    memAddrHigh = 20'h00000;
    overtempAlertIn = 1'b0;
    sysMgmtIrqIn = 1'b0;
    void'($urandom(32'hff81));
    do_reset(1'b1);
    i_host.rd(port + 8'h01, q, v);
    chk(v, 1'b0, "data port outside config");
    i_host.enter(8'h2e);
    chk(cfgMode, 1'b0, "entry on unselected port");
    i_host.enter(port);
    chk(cfgMode, 1'b1, "entry on strapped port");
    chk_reset_vals();
    $display("test reset values done");
    acc(OFS_IRQ_PORT, 8'h60);
    acc(OFS_ROM_DEC, 8'h1b);
    acc(OFS_IRQ_PORT, 8'h4f);
    $display("test lock done");
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      if (tbl[i % 5] == OFS_IRQ_PORT) d[6] = m26[6];
      if (tbl[i % 5] == OFS_ROM_DEC) d[2] = 1'b0;
      if (tbl[i % 5] == OFS_PIN_FUNC) d[2] = 1'b0;
      acc(tbl[i % 5], d);
    end
    $display("test random access done");
    acc(OFS_IRQ_PORT, m26 & 8'h40);
    old = port;
    acc(OFS_IRQ_PORT, 8'h00);
    i_host.leave(port);
    chk(cfgMode, 1'b0, "exit on new port");
    i_host.enter(old);
    chk(cfgMode, 1'b0, "entry on old port");
    i_host.enter(port);
    chk(cfgMode, 1'b1, "entry on new port");
    $display("test port select done");
    i_host.leave(port);
    i_host.wr(port, ENTRY_KEY);
    i_host.wr(port, 8'h55);
    i_host.wr(port, ENTRY_KEY);
    chk(cfgMode, 1'b0, "broken key pair");
    i_host.wr(port, ENTRY_KEY);
    chk(cfgMode, 1'b1, "key pair after abort");
    $display("test key abort done");
    do_reset(1'b0);
    i_host.enter(port);
    chk(cfgMode, 1'b1, "entry after second reset");
    chk_reset_vals();
    $display("test second reset done");
    give_verdict();
  end

endmodule : gocr_regs_tb_top
